/* File: core/vrc_regs.svh */
// register offsets, field positions and reset values of the reference control
`ifndef VRC_REGS_SVH
`define VRC_REGS_SVH
`define VRC_BASE_ADDR 16'h9800
`define VRC_OFS_VALUE 4'h0
`define VRC_OFS_CLR 4'h4
`define VRC_OFS_SET 4'h8
`define VRC_OFS_INV 4'hC
`define VRC_BIT_ENABLE 15
`define VRC_BIT_PIN_OE 6
`define VRC_BIT_RANGE 5
`define VRC_BIT_SOURCE 4
`define VRC_LEVEL_MSB 3
`define VRC_IMPL_MASK 32'h0000807F
`define VRC_RESET_VALUE 32'h00000000
`define VRC_RESP_OKAY 2'h0
`define VRC_RESP_SLVERR 2'h2
`endif

/* File: core/vrc_pkg.sv */
// types of the voltage reference control block
package vrc_pkg;
  typedef enum logic [1:0] {
    VRC_OP_WRITE,
    VRC_OP_CLEAR,
    VRC_OP_SET,
    VRC_OP_INVERT
  } vrc_op_t;
endpackage

/* File: core/vrc_alias_update.sv */
// applies a plain, clear, set or invert alias write to the control word
`timescale 1ns/1ps
`default_nettype none
`include "vrc_regs.svh"
module vrc_alias_update (
  input wire vrc_pkg::vrc_op_t op,
  input wire logic [31:0] cur,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic [31:0] result
);
  logic [31:0] lane_mask;
  logic [31:0] wval;
  logic [31:0] raw;

  always_comb begin
    lane_mask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
    wval = wdata & lane_mask;
    case (op)
      vrc_pkg::VRC_OP_WRITE: raw = (cur & ~lane_mask) | wval;
      vrc_pkg::VRC_OP_CLEAR: raw = cur & ~wval;
      vrc_pkg::VRC_OP_SET: raw = cur | wval;
      vrc_pkg::VRC_OP_INVERT: raw = cur ^ wval;
      default: raw = cur;
    endcase
    // unimplemented bits can never be stored
    result = raw & `VRC_IMPL_MASK;
  end
endmodule
`default_nettype wire

/* File: core/vrc_ctrl_top.sv */
// voltage reference control register with an AXI4-Lite slave port
//
// Summary of operation
// - bit 15 enables ladder, others untouched only via clear, set, invert aliases
// - bit 6 connects level to pin
// - bit 5 selects high or low range
// - bit 4 selects external or supply source
// - bits 3..0 pick one of sixteen levels
// - high range adds quarter source offset
// - unimplemented bits read zero, ignore writes
// - reset clears whole register to zero
// - clear, set, invert aliases at 4, 8, C
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "vrc_regs.svh"
module vrc_ctrl_top (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic ref_enable,
  output logic ref_pin_output_enable,
  output logic ref_range_select,
  output logic ref_source_select,
  output logic [3:0] ref_level_select
);
  typedef struct packed {
    logic aw_held;
    logic [15:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] ctrl;
  } vrc_state_t;

  vrc_state_t state_ff;
  vrc_state_t nxt_state;
  vrc_pkg::vrc_op_t wr_op;
  logic wr_hit;
  logic rd_hit;
  logic [31:0] upd_value;

  // the slave holds one of each until the response leaves
  assign s_axi_awready = !state_ff.aw_held && !state_ff.bvalid;
  assign s_axi_wready = !state_ff.w_held && !state_ff.bvalid;
  assign s_axi_arready = !state_ff.rvalid;
  assign s_axi_bvalid = state_ff.bvalid;
  assign s_axi_bresp = state_ff.bresp;
  assign s_axi_rvalid = state_ff.rvalid;
  assign s_axi_rdata = state_ff.rdata;
  assign s_axi_rresp = state_ff.rresp;

  // all four aliases share the word base; low two bits ignored
  always_comb begin
    wr_hit = state_ff.awaddr[15:4] == 12'(`VRC_BASE_ADDR >> 4);
    rd_hit = s_axi_araddr[15:4] == 12'(`VRC_BASE_ADDR >> 4);
    case (state_ff.awaddr[3:2])
      2'h1: wr_op = vrc_pkg::VRC_OP_CLEAR;
      2'h2: wr_op = vrc_pkg::VRC_OP_SET;
      2'h3: wr_op = vrc_pkg::VRC_OP_INVERT;
      default: wr_op = vrc_pkg::VRC_OP_WRITE;
    endcase
  end

  vrc_alias_update u_alias (
    .op(wr_op),
    .cur(state_ff.ctrl),
    .wdata(state_ff.wdata),
    .wstrb(state_ff.wstrb),
    .result(upd_value)
  );

  always_comb begin
    nxt_state = state_ff;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_state.aw_held = 1'b1;
      nxt_state.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_state.w_held = 1'b1;
      nxt_state.wdata = s_axi_wdata;
      nxt_state.wstrb = s_axi_wstrb;
    end
    if (state_ff.aw_held && state_ff.w_held) begin
      nxt_state.aw_held = 1'b0;
      nxt_state.w_held = 1'b0;
      nxt_state.bvalid = 1'b1;
      if (wr_hit) begin
        // plain write replaces all strobed lanes; only clear, set, invert leave other bits alone
        nxt_state.ctrl = upd_value;
        nxt_state.bresp = `VRC_RESP_OKAY;
      end else begin
        nxt_state.bresp = `VRC_RESP_SLVERR;
      end
    end
    if (state_ff.bvalid && s_axi_bready) begin
      nxt_state.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_state.rvalid = 1'b1;
      if (rd_hit) begin
        // every alias reads back the control word
        nxt_state.rdata = state_ff.ctrl & `VRC_IMPL_MASK;
        nxt_state.rresp = `VRC_RESP_OKAY;
      end else begin
        nxt_state.rdata = 32'h00000000;
        nxt_state.rresp = `VRC_RESP_SLVERR;
      end
    end else if (state_ff.rvalid && s_axi_rready) begin
      nxt_state.rvalid = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_ff <= '0;
      state_ff.ctrl <= `VRC_RESET_VALUE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // no decode between flops and ladder: analog sees clean levels
  assign ref_enable = state_ff.ctrl[`VRC_BIT_ENABLE];
  assign ref_pin_output_enable = state_ff.ctrl[`VRC_BIT_PIN_OE];
  // range and level together set the tap; the ladder does the math
  assign ref_range_select = state_ff.ctrl[`VRC_BIT_RANGE];
  assign ref_source_select = state_ff.ctrl[`VRC_BIT_SOURCE];
  assign ref_level_select = state_ff.ctrl[`VRC_LEVEL_MSB:0];

  // protection bits carry no meaning for this register
  logic unused_prot;
  assign unused_prot = ^{s_axi_awprot, s_axi_arprot};
endmodule
`default_nettype wire

/* File: tb/vrc_chk_assertions.sv */
// port assertions for the reference control register
`timescale 1ns/1ps
`default_nettype none
module vrc_chk (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic ref_enable,
  input wire logic ref_pin_output_enable,
  input wire logic ref_range_select,
  input wire logic ref_source_select,
  input wire logic [3:0] ref_level_select
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  wire logic [15:0] ctl = {ref_enable, 8'h00, ref_pin_output_enable,
    ref_range_select, ref_source_select, ref_level_select};
  zero_bits_a: assert property (s_axi_rvalid |->
    !{s_axi_rdata[31:16], s_axi_rdata[14:7]}) else $error("bits");
  reset_zero_a: assert property ($rose(rstn) |-> !ctl)
    else $error("reset");
  read_mirror_a: assert property ($rose(s_axi_rvalid) &&
    |s_axi_rdata |-> s_axi_rdata[15:0] == ctl) else $error("mirror");
  en_write_a: assert property ($changed(ref_enable) |->
    $rose(s_axi_bvalid)) else $error("enable");
  oe_write_a: assert property (!$stable(ref_pin_output_enable) |->
    s_axi_bvalid && !$past(s_axi_bvalid)) else $error("oe");
  range_hold_a: assert property (!$rose(s_axi_bvalid) |->
    $stable(ref_range_select)) else $error("range");
  src_hold_a: assert property ($stable(s_axi_bvalid) |->
    $stable(ref_source_select)) else $error("source");
  level_hold_a: assert property (!s_axi_bvalid [*2] |->
    $stable(ref_level_select)) else $error("level");
endmodule
bind vrc_ctrl_top vrc_chk chk_u (.*);
`default_nettype wire

/* File: tb/vrc_ladder.sv */
// ladder model: pin level in 96ths of the source
`timescale 1ns/1ps
`default_nettype none
module vrc_ladder (
  input wire logic en,
  input wire logic oe,
  input wire logic rng,
  input wire logic [3:0] lvl,
  output logic [6:0] pin
);
  // a disconnected pin floats, shown as all ones, never a stale level
  assign pin = !oe ? 7'h7F : !en ? 7'h00 :
    rng ? {1'h0, lvl, 2'h0} :
    7'h18 + {3'h0, lvl} * 7'h03;
endmodule
`default_nettype wire

/* File: tb/voltage_reference_control_regs_tb.sv */
// AXI4-Lite bench for the reference control register
`timescale 1ns/1ps
`default_nettype none
module voltage_reference_control_regs_tb;
  logic sys_clk = 0, rstn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [15:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, ref_enable, ref_pin_output_enable, ref_range_select;
  logic ref_source_select;
  logic [3:0] ref_level_select;
  logic [6:0] pin;
  int fail_count = 0, total_checks = 0, cyc = 0, e;
  vrc_ctrl_top dut_u (.*, .s_axi_awprot(3'h0), .s_axi_arprot(3'h0),
    .s_axi_wstrb(4'hF));
  vrc_ladder lad_u (.en(ref_enable), .oe(ref_pin_output_enable),
    .rng(ref_range_select), .lvl(ref_level_select), .pin);
  initial forever #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (++cyc > 3000) conclude(1);
  task chk(input logic [33:0] g, input logic [33:0] x);
    total_checks++;
    if (g !== x) begin
      fail_count++;
      $display("BAD %0t %h %h", $time, g, x);
    end
  endtask
  // optional write, then a read back compared as {rresp, rdata}
  task acc(input logic w, input logic [15:0] a, input logic [31:0] d,
    input logic [33:0] x);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {w, w, w};
    while (w) begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) s_axi_bready <= 1'h0;
      w = !s_axi_bvalid;
    end
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk({s_axi_rresp, s_axi_rdata}, x);
  endtask
  task conclude(input int t);
    fail_count += t;
    $display("checks %0d bad %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    rstn <= 1'h1;
    acc(0, 16'h9800, 32'h0, 34'h0);
    acc(1, 16'h9800, 32'hFFFFFFFF, 34'h807F);
    acc(1, 16'h9804, 32'h8000, 34'h7F);
    acc(1, 16'h9808, 32'h8000, 34'h807F);
    acc(1, 16'h980C, 32'h70, 34'h800F);
    chk(34'(pin), 34'h7F);
    for (int i = 0; i < 64; i++) begin
      acc(1, 16'h9800, {16'h0, 10'h201, i[5:0]}, {18'h0, 10'h201, i[5:0]});
      e = i[5] ? i[3:0] * 96 / 24 : 96 / 4 + i[3:0] * 96 / 32;
      chk(34'(pin), 34'(e));
      chk(34'(ref_source_select), 34'(i[4]));
    end
    acc(1, 16'h9804, 32'h8000, 34'h7F);
    chk(34'(pin), 34'h0);
    acc(0, 16'h9810, 32'h0, 34'h200000000);
    conclude(0);
  end
endmodule
`default_nettype wire
